//--- mcu_decode_pkg.sv
// constants, encodings and carrier types for the instruction decoder
// assumes a 16-bit instruction word and a 21-bit byte-addressed program counter
package mcu_decode_pkg;

  localparam int word_width = 16;
  localparam int pc_width = 21;

  // opcode patterns
  localparam logic [5:0] sub_w_from_file_code = 6'h17;
  localparam logic [5:0] sub_w_from_file_borrow_code = 6'h16;
  localparam logic [5:0] xor_w_file_code = 6'h06;
  localparam logic [3:0] bit_clear_file_code = 4'h9;
  localparam logic [3:0] bit_test_skip_set_code = 4'hb;
  localparam logic [4:0] cond_branch_code = 5'h1c;
  localparam logic [6:0] call_code = 7'h76;
  localparam logic [7:0] absolute_jump_code = 8'hef;
  localparam logic [3:0] second_word_code = 4'hf;
  localparam logic [15:0] stack_pop_code = 16'h0006;
  localparam logic [15:0] stack_push_code = 16'h0005;
  localparam logic [14:0] interrupt_return_code = 15'h0008;
  localparam logic [7:0] literal_return_code = 8'h0c;
  localparam logic [15:0] sleep_code = 16'h0003;
  localparam logic [15:0] nop_code = 16'h0000;

  // field positions
  localparam int top_nibble_lsb = 12;
  localparam int dest_bit = 9;
  localparam int access_bit = 8;
  localparam int bit_num_lsb = 9;
  localparam int cond_lsb = 8;

  // branch conditions
  localparam logic [2:0] cond_zero = 3'h0;
  localparam logic [2:0] cond_not_zero = 3'h1;
  localparam logic [2:0] cond_carry = 3'h2;
  localparam logic [2:0] cond_not_carry = 3'h3;
  localparam logic [2:0] cond_overflow = 3'h4;
  localparam logic [2:0] cond_not_overflow = 3'h5;
  localparam logic [2:0] cond_negative = 3'h6;
  localparam logic [2:0] cond_not_negative = 3'h7;

  // reset values
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [pc_width-1:0] target_reset = 21'h000000;

  typedef enum logic [1:0] {
    st_exec = 2'h0,
    st_second = 2'h1,
    st_flush = 2'h2
  } decode_state_t;

  typedef enum logic [3:0] {
    op_nop = 4'h0,
    op_sub = 4'h1,
    op_sub_borrow = 4'h2,
    op_xor = 4'h3,
    op_bit_clear = 4'h4,
    op_bit_test = 4'h5,
    op_branch = 4'h6,
    op_call = 4'h7,
    op_jump = 4'h8,
    op_pop = 4'h9,
    op_push = 4'ha,
    op_irq_return = 4'hb,
    op_lit_return = 4'hc,
    op_sleep = 4'hd,
    op_other = 4'he
  } op_t;

  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
    logic sign_wrap_flag;
    logic negative;
  } flags_t;

  typedef struct packed {
    logic valid;
    logic nop_cycle;
    op_t op;
    logic dest_file;
    logic access_bank;
    logic [7:0] file_addr;
    logic [2:0] bit_num;
    logic [7:0] literal;
    flags_t flag_mask;
    logic pc_load;
    logic [pc_width-1:0] target;
    logic stack_push;
    logic stack_pop;
    logic fast_restore;
    logic global_high_irq_enable;
    logic periph_low_irq_enable;
    logic sleep;
    logic watchdog_expired_flag;
    logic sleep_entered_flag;
    logic pins_read;
    logic prescaler_clear;
  } decode_t;

  localparam flags_t flags_none = '{default: 1'b0};
  localparam flags_t flags_arith = '{default: 1'b1};
  localparam flags_t flags_logic = '{carry: 1'b0, half_carry_flag: 1'b0, zero: 1'b1,
                                     sign_wrap_flag: 1'b0, negative: 1'b1};
  localparam decode_t decode_idle = '{op: op_nop, target: target_reset, default: '0};

endpackage

//--- mcu_instruction_decode.sv
// decoder for the subtract/xor, bit-oriented and control instructions
// assumes words are offered on fetch_valid with the incremented pc alongside,
// and the datapath answers tested_bit and address hits in the same cycle
`timescale 1ns/1ps
`default_nettype none

module mcu_instruction_decode
  import mcu_decode_pkg::*;
(
  // clock, reset, enable
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  // instruction fetch
  input wire logic fetch_valid,
  input wire logic [word_width-1:0] fetch_word,
  input wire logic [pc_width-1:0] pc_incr,
  output logic fetch_ready,
  // datapath answers
  input wire mcu_decode_pkg::flags_t status,
  input wire logic tested_bit,
  input wire logic port_hit,
  input wire logic timer_zero_count_hit,
  input wire logic prescaler_assigned,
  // table write progress
  input wire logic table_write_start,
  input wire logic table_write_done,
  output logic table_write_active,
  // decoded instruction
  output mcu_decode_pkg::decode_t decoded
);
  import mcu_decode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    decode_state_t state;
    logic skip_next;
    logic call_pending;
    logic fast_pending;
    logic [7:0] low_byte;
    logic write_hold;
    decode_t out;
  } core_t;

  core_t core;
  core_t next_core;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic branch_taken(input logic [2:0] cond, input flags_t f);
    logic hit;
    hit = 1'b0;
    unique case (cond)
      cond_zero: hit = f.zero;
      cond_not_zero: hit = !f.zero;
      cond_carry: hit = f.carry;
      cond_not_carry: hit = !f.carry;
      cond_overflow: hit = f.sign_wrap_flag;
      cond_not_overflow: hit = !f.sign_wrap_flag;
      cond_negative: hit = f.negative;
      cond_not_negative: hit = !f.negative;
    endcase
    return hit;
  endfunction

  // offset counts words, so it is doubled to stay on word boundaries
  function automatic logic [pc_width-1:0] rel_target(input logic [pc_width-1:0] pc,
                                                     input logic [7:0] offset);
    logic [pc_width-1:0] ext;
    ext = {{(pc_width - 9){offset[7]}}, offset, 1'b0};
    return pc + ext;
  endfunction

  // byte-oriented fields shared by every file-register form
  function automatic decode_t file_fields(input decode_t base, input logic [15:0] w);
    decode_t d;
    d = base;
    d.dest_file = w[dest_bit];
    d.access_bank = !w[access_bit];
    d.file_addr = w[7:0];
    return d;
  endfunction

  assign fetch_ready = enable;
  assign table_write_active = core.write_hold;
  assign decoded = core.out;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic take;
    logic writes_file;
    decode_t d;
    take = enable && fetch_valid;
    writes_file = 1'b0;
    d = decode_idle;
    next_core = core;
    next_core.out = decode_idle;

    // only its own completion or a reset ends a table write; no instruction aborts it
    if (table_write_start) begin
      next_core.write_hold = 1'b1;
    end else if (table_write_done) begin
      next_core.write_hold = 1'b0;
    end

    if (take) begin
      d.valid = 1'b1;
      unique case (core.state)
        st_flush: begin
          // second cycle of a taken branch or a return runs as a no-op
          d.nop_cycle = 1'b1;
          next_core.state = st_exec;
        end
        st_second: begin
          next_core.state = st_exec;
          if (fetch_word[15:top_nibble_lsb] == second_word_code) begin
            d.op = core.call_pending ? op_call : op_jump;
            d.pc_load = 1'b1;
            d.target = {fetch_word[11:0], core.low_byte, 1'b0};
            d.stack_push = core.call_pending;
            d.fast_restore = core.fast_pending;
          end else begin
            d.op = op_other;
          end
        end
        st_exec: begin
          if (core.skip_next) begin
            // a skipped two-word first word leaves its 1111 word to run as no-op
            d.nop_cycle = 1'b1;
            next_core.skip_next = 1'b0;
          end else if (fetch_word[15:10] == sub_w_from_file_code) begin
            d = file_fields(d, fetch_word);
            d.op = op_sub;
            d.flag_mask = flags_arith;
            writes_file = 1'b1;
          end else if (fetch_word[15:10] == sub_w_from_file_borrow_code) begin
            d = file_fields(d, fetch_word);
            d.op = op_sub_borrow;
            d.flag_mask = flags_arith;
            writes_file = 1'b1;
          end else if (fetch_word[15:10] == xor_w_file_code) begin
            d = file_fields(d, fetch_word);
            d.op = op_xor;
            d.flag_mask = flags_logic;
            writes_file = 1'b1;
          end else if (fetch_word[15:top_nibble_lsb] == bit_clear_file_code) begin
            d = file_fields(d, fetch_word);
            d.dest_file = 1'b1;
            d.op = op_bit_clear;
            d.bit_num = fetch_word[11:bit_num_lsb];
            d.flag_mask = flags_none;
            writes_file = 1'b1;
          end else if (fetch_word[15:top_nibble_lsb] == bit_test_skip_set_code) begin
            d = file_fields(d, fetch_word);
            d.dest_file = 1'b0;
            d.op = op_bit_test;
            d.bit_num = fetch_word[11:bit_num_lsb];
            next_core.skip_next = tested_bit;
          end else if (fetch_word[15:11] == cond_branch_code) begin
            d.op = op_branch;
            d.target = rel_target(pc_incr, fetch_word[7:0]);
            if (branch_taken(fetch_word[10:cond_lsb], status)) begin
              d.pc_load = 1'b1;
              next_core.state = st_flush;
            end
          end else if (fetch_word[15:9] == call_code
                       || fetch_word[15:8] == absolute_jump_code) begin
            // completes when the second word arrives
            d.valid = 1'b0;
            d.op = op_nop;
            next_core.call_pending = (fetch_word[15:9] == call_code);
            // only a call carries the fast bit; a jump's bit 8 is part of its opcode
            next_core.fast_pending = (fetch_word[15:9] == call_code) && fetch_word[8];
            next_core.low_byte = fetch_word[7:0];
            next_core.state = st_second;
          end else if (fetch_word[15:top_nibble_lsb] == second_word_code) begin
            d.op = op_nop;
            d.nop_cycle = 1'b1;
          end else if (fetch_word == stack_pop_code) begin
            d.op = op_pop;
            d.stack_pop = 1'b1;
          end else if (fetch_word == stack_push_code) begin
            d.op = op_push;
            d.stack_push = 1'b1;
          end else if (fetch_word[15:1] == interrupt_return_code) begin
            d.op = op_irq_return;
            d.stack_pop = 1'b1;
            d.pc_load = 1'b1;
            d.fast_restore = fetch_word[0];
            d.global_high_irq_enable = 1'b1;
            d.periph_low_irq_enable = 1'b1;
            next_core.state = st_flush;
          end else if (fetch_word[15:8] == literal_return_code) begin
            d.op = op_lit_return;
            d.literal = fetch_word[7:0];
            d.stack_pop = 1'b1;
            d.pc_load = 1'b1;
            next_core.state = st_flush;
          end else if (fetch_word == sleep_code) begin
            d.op = op_sleep;
            d.sleep = 1'b1;
            d.watchdog_expired_flag = 1'b1;
            d.sleep_entered_flag = 1'b1;
          end else if (fetch_word == nop_code) begin
            d.op = op_nop;
          end else begin
            d.op = op_other;
          end
        end
        default: begin
          d.op = op_other;
          next_core.state = st_exec;
        end
      endcase

      // rmw of a port sees the pins, so a pin held low writes back zero
      d.pins_read = writes_file && port_hit;
      // the w-only destination form leaves the timer untouched
      d.prescaler_clear = writes_file && d.dest_file
                          && timer_zero_count_hit && prescaler_assigned;
      next_core.out = d;
    end else if (!enable) begin
      next_core = core;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock) begin
    if (reset) begin
      core.state <= st_exec;
      core.skip_next <= 1'b0;
      core.call_pending <= 1'b0;
      core.fast_pending <= 1'b0;
      core.low_byte <= byte_reset;
      core.write_hold <= 1'b0;
      core.out <= decode_idle;
    end else if (enable) begin
      core <= next_core;
    end
  end

endmodule

`default_nettype wire

//--- decode_checker_assertions.sv
// port assertions for the instruction decoder
// assumes it is bound onto every mcu_instruction_decode instance
`timescale 1ns/1ps
`default_nettype none
module decode_checker
  import mcu_decode_pkg::*;
(
  // clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  // fetch and datapath inputs
  input wire logic fetch_valid,
  input wire logic [mcu_decode_pkg::word_width-1:0] fetch_word,
  input wire logic [mcu_decode_pkg::pc_width-1:0] pc_incr,
  input wire logic timer_zero_count_hit,
  input wire logic prescaler_assigned,
  input wire logic table_write_done,
  // outputs
  input wire logic table_write_active,
  input wire mcu_decode_pkg::decode_t decoded
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  // plain ops leave no flush or pending pair, so the next word decodes afresh
  wire go = enable && fetch_valid && decoded.valid &&
    decoded.op inside {op_sub, op_sub_borrow, op_xor, op_bit_clear};
  sub_decode_a: assert property (go && fetch_word[15:10] == 6'h17
    |=> decoded.op == op_sub && decoded.flag_mask == flags_arith) else $error("sub decode");
  bit_clear_a: assert property (go && fetch_word[15:12] == 4'h9
    |=> decoded.op == op_bit_clear && decoded.flag_mask == flags_none &&
    decoded.bit_num == $past(fetch_word[11:9])) else $error("bit clear decode");
  branch_target_a: assert property (go && fetch_word[15:11] == 5'h1c
    |=> decoded.op == op_branch && (!decoded.pc_load || decoded.target ==
    $past(pc_incr) + {{12{$past(fetch_word[7])}}, $past(fetch_word[7:0]), 1'b0}))
    else $error("branch target");
  branch_flush_a: assert property (decoded.pc_load && decoded.op == op_branch &&
    enable && fetch_valid |=> decoded.nop_cycle && decoded.op == op_nop) else $error("no flush");
  stack_pop_a: assert property (go && fetch_word == 16'h0006
    |=> decoded.stack_pop && !decoded.stack_push) else $error("pop decode");
  sleep_flags_a: assert property (go && fetch_word == 16'h0003
    |=> decoded.sleep && decoded.watchdog_expired_flag && decoded.sleep_entered_flag)
    else $error("sleep decode");
  write_hold_a: assert property (table_write_active && !table_write_done
    |=> table_write_active) else $error("table write dropped");
  presc_clear_a: assert property (go && fetch_word[15:9] == 7'h2f && prescaler_assigned
    && timer_zero_count_hit |=> decoded.prescaler_clear) else $error("prescaler kept");
endmodule
bind mcu_instruction_decode decode_checker i_chk (.clock(clock), .reset(reset),
  .enable(enable), .fetch_valid(fetch_valid), .fetch_word(fetch_word), .pc_incr(pc_incr),
  .timer_zero_count_hit(timer_zero_count_hit), .prescaler_assigned(prescaler_assigned),
  .table_write_done(table_write_done), .table_write_active(table_write_active),
  .decoded(decoded));
`default_nettype wire

//--- fetch_source.sv
// program memory fetch model: presents one word per falling edge
// assumes the bench changes want_* only after a rising edge
`timescale 1ns/1ps
`default_nettype none
module fetch_source
  import mcu_decode_pkg::*;
(
  // clock and request
  input wire logic clock,
  input wire logic want_valid,
  input wire logic [mcu_decode_pkg::word_width-1:0] want_word,
  input wire logic [mcu_decode_pkg::pc_width-1:0] want_pc,
  // fetch side
  output logic fetch_valid = 1'b0,
  output logic [mcu_decode_pkg::word_width-1:0] fetch_word = '0,
  output logic [mcu_decode_pkg::pc_width-1:0] pc_incr = '0
);
  // an idle bus shows the inverse word so stale data never passes for valid
  always @(negedge clock) begin
    fetch_valid <= want_valid;
    fetch_word <= want_valid ? want_word : ~fetch_word;
    pc_incr <= want_pc;
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// random and corner tests of the instruction decoder
// assumes package, design, checker and fetch model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mcu_decode_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic enable = 1'b1;
  logic want_valid = 1'b0;
  logic [15:0] want_word = 16'h0000;
  logic [20:0] want_pc = 21'h000000;
  flags_t status = '0;
  logic tested_bit = 1'b0, port_hit = 1'b0, tmr_hit = 1'b0, presc = 1'b0;
  logic tw_start = 1'b0, tw_done = 1'b0, flush = 1'b0, have_first = 1'b0;
  logic fetch_valid, fetch_ready, table_write_active;
  logic [15:0] fetch_word, first;
  logic [20:0] pc_incr;
  decode_t decoded;
  int n_mismatch = 0, total_checks = 0;
  always #4 clock = ~clock;
  fetch_source i_src (.clock(clock), .want_valid(want_valid), .want_word(want_word),
    .want_pc(want_pc), .fetch_valid(fetch_valid), .fetch_word(fetch_word), .pc_incr(pc_incr));
  mcu_instruction_decode i_dut (.clock(clock), .reset(reset), .enable(enable),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .pc_incr(pc_incr),
    .fetch_ready(fetch_ready), .status(status), .tested_bit(tested_bit), .port_hit(port_hit),
    .timer_zero_count_hit(tmr_hit), .prescaler_assigned(presc), .table_write_start(tw_start),
    .table_write_done(tw_done), .table_write_active(table_write_active), .decoded(decoded));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] want, input logic [31:0] got);
    total_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic taken(input logic [2:0] c, input flags_t s);
    return c[0] ^ (c[2] ? (c[1] ? s.negative : s.sign_wrap_flag) : (c[1] ? s.carry : s.zero));
  endfunction
  function automatic op_t ref_op(input logic [15:0] w);
    if (w[15:10] == 6'h17) return op_sub;
    if (w[15:10] == 6'h16) return op_sub_borrow;
    if (w[15:10] == 6'h06) return op_xor;
    if (w[15:12] == 4'h9) return op_bit_clear;
    if (w[15:12] == 4'hb) return op_bit_test;
    if (w[15:11] == 5'h1c) return op_branch;
    if (w == 16'h0006) return op_pop;
    if (w == 16'h0005) return op_push;
    if (w[15:1] == 15'h0008) return op_irq_return;
    if (w[15:8] == 8'h0c) return op_lit_return;
    if (w == 16'h0003) return op_sleep;
    if (w == 16'h0000) return op_nop;
    return op_other;
  endfunction
  ////////////////////////////////////////////////////////////////
  // one word per cycle; expectations follow a small model of flush and pairing
  task automatic step(input logic [15:0] w, input logic tb_bit);
    logic [7:0] r;
    op_t op;
    logic valid, nop, load, bc;
    logic [20:0] tgt;
    decode_t d;
    r = 8'($urandom);
    want_valid = 1'b1;
    want_word = w;
    want_pc = want_pc + 21'h2;
    @(negedge clock);
    status <= flags_t'(r[4:0]);
    {presc, tmr_hit, port_hit} <= r[7:5];
    tested_bit <= tb_bit;
    @(posedge clock);
    #1;
    d = decoded;
    {valid, nop, load} = 3'h4;
    op = op_nop;
    tgt = {w[11:0], first[7:0], 1'b0};
    if (flush || (!have_first && w[15:12] == 4'hf)) begin
      nop = 1'b1;
      flush = 1'b0;
    end else if (have_first) begin
      op = w[15:12] != 4'hf ? op_other : first[9] ? op_jump : op_call;
      load = op != op_other;
      have_first = 1'b0;
    end else if (w[15:9] == 7'h76 || w[15:8] == 8'hef) begin
      valid = 1'b0;
      have_first = 1'b1;
      first = w;
    end else begin
      op = ref_op(w);
      load = op == op_branch && taken(w[10:8], flags_t'(r[4:0]));
      if (load) tgt = want_pc + {{12{w[7]}}, w[7:0], 1'b0};
      flush = load || op inside {op_irq_return, op_lit_return} || (op == op_bit_test && tb_bit);
    end
    bc = op == op_bit_clear;
    chk("valid", valid, d.valid);
    if (valid) begin
      chk("op", op, d.op);
      chk("nop", nop, d.nop_cycle);
      case (op)
        op_sub, op_sub_borrow, op_xor, op_bit_clear: begin
          chk("mask", op == op_xor ? 5'h05 : bc ? 5'h00 : 5'h1f, d.flag_mask);
          chk("dest", {w[9] | bc, !w[8], w[7:0]}, {d.dest_file, d.access_bank, d.file_addr});
          chk("pins", r[5], d.pins_read);
          chk("presc", r[6] & r[7] & (w[9] | bc), d.prescaler_clear);
        end
        op_branch, op_call, op_jump: begin
          chk("load", load, d.pc_load);
          chk("push", op == op_call, d.stack_push);
          if (load) chk("target", tgt, d.target);
          if (op != op_branch) chk("fast", op == op_call && first[8], d.fast_restore);
        end
        op_irq_return: begin
          chk("irq", 2'h3, {d.global_high_irq_enable, d.periph_low_irq_enable});
          chk("fast", w[0], d.fast_restore);
        end
        op_push, op_pop: chk("stack", w[1:0], {d.stack_pop, d.stack_push});
        op_lit_return: chk("lit", w[7:0], d.literal);
        op_bit_test: chk("bit", w[11:9], d.bit_num);
        op_sleep: chk("slp", 3'h7, {d.sleep, d.watchdog_expired_flag, d.sleep_entered_flag});
        default: ;
      endcase
    end
  endtask
  task automatic rand_word;
    logic [15:0] r, w;
    r = 16'($urandom);
    case ($urandom_range(11))
      0: w = {6'h17, r[9:0]};
      1: w = {6'h16, r[9:0]};
      2: w = {6'h06, r[9:0]};
      3: w = {4'h9, r[11:0]};
      4: w = {4'hb, r[11:0]};
      5, 6: w = {5'h1c, r[10:0]};
      7: w = {15'h0008, r[0]};
      8: w = {8'h0c, r[7:0]};
      9: w = {14'h0001, r[0], ~r[0]};
      10: w = 16'h0003;
      default: begin
        step(r[9] ? {8'hef, r[7:0]} : {7'h76, r[8:0]}, 1'b0);
        w = {4'hf, r[11:0]};
      end
    endcase
    step(w, r[15]);
  endtask
  task automatic do_reset;
    want_valid = 1'b0;
    @(negedge clock);
    reset <= 1'b1;
    repeat (6) @(negedge clock);
    chk("idle", 1'b1, decoded === decode_idle && table_write_active === 1'b0);
    reset <= 1'b0;
    {flush, have_first} = 2'h0;
    @(posedge clock);
    #1;
  endtask
  // start and done together: start wins, then the write runs until done
  task automatic table_write;
    @(negedge clock);
    {tw_start, tw_done} <= 2'h3;
    @(negedge clock);
    {tw_start, tw_done} <= 2'h0;
    repeat (30) @(negedge clock);
    chk("tw_busy", 1'b1, table_write_active);
    tw_done <= 1'b1;
    @(negedge clock);
    tw_done <= 1'b0;
    chk("tw_idle", 1'b0, table_write_active);
  endtask
  task automatic freeze;
    decode_t held;
    want_valid = 1'b0;
    @(negedge clock);
    enable <= 1'b0;
    held = decoded;
    repeat (4) @(negedge clock);
    chk("hold", 1'b1, decoded === held && fetch_ready === 1'b0);
    enable <= 1'b1;
    @(posedge clock);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    // fast call pair, then a jump whose second word is not a 1111 word
    logic [15:0] corner [9] = '{16'hf123, 16'hec12, 16'hf345, 16'h0011, 16'he080,
                               16'hed34, 16'hf000, 16'hef01, 16'h0000};
    void'($urandom(32'haf81e7d3));
    do_reset();
    foreach (corner[i]) step(corner[i], 1'b1);
    fork
      repeat (300) rand_word();
      table_write();
    join
    step(16'h5e20, 1'b0);
    freeze();
    do_reset();
    repeat (100) rand_word();
    stop_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
